// *** core/scl_control_latch.sv ***
// module: serial input register, latch routing, init reset pulse and power-down control
`default_nettype none

// ==========================================================
module scl_control_latch
    import scl_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_serial_clk,
    input wire logic i_serial_data,
    input wire logic i_latch_enable_pin,
    input wire logic i_chip_enable_pin,
    input wire logic i_pump_event,
    output var scl_pkg::scl_synth_ctrl_t o_ctrl,
    output logic o_powerdown
);
    import scl_pkg::*;

    // ==========================================================
    // link domain: input shift register on the serial clock
    typedef struct packed {
        logic [WORD_W-1:0] shift;
    } scl_link_state_t;

    scl_link_state_t link_reg;
    scl_link_state_t link_next;

    // no reset here: the serial clock only runs inside frames, and the
    // word content is meaningless until the host shifts a full one
    always_comb
    begin
        link_next = link_reg;
        link_next.shift = {link_reg.shift[WORD_W-2:0], i_serial_data};
    end

    always_ff @(posedge i_serial_clk)
    begin
        link_reg <= link_next;
    end

    // ==========================================================
    // core domain state
    typedef struct packed {
        logic le_meta;
        logic le_sync;
        logic le_prev;
        logic ce_meta;
        logic ce_sync;
        scl_func_t func;
        logic [PAYLOAD_W-1:0] reference_word;
        logic [PAYLOAD_W-1:0] divide_word;
        logic reference_load;
        logic divide_load;
        logic init_armed;
        logic reset_pulse;
        logic sync_pd_active;
        logic async_pd_active;
    } scl_core_state_t;

    scl_core_state_t core_reg;
    scl_core_state_t core_next;

    logic le_rise;
    logic [WORD_W-1:0] word;
    logic [SEL_W-1:0] word_sel;
    scl_func_t word_func;
    logic [PAYLOAD_W-1:0] word_payload;
    logic sync_pd_armed;
    logic async_pd_armed;

    // the shift register stands still between the last serial edge and the
    // latch enable rise, so a two-stage delayed enable makes it safe to copy
    assign le_rise = core_reg.le_sync & ~core_reg.le_prev;
    assign word = link_reg.shift;
    assign word_sel = word[SEL_LSB +: SEL_W];
    assign word_payload = word[PAYLOAD_LSB +: PAYLOAD_W];
    assign word_func = scl_func_t'(word_payload);

    // programmed power-down modes as held in the function settings
    assign async_pd_armed = core_reg.func.powerdown_first_bit
        & ~core_reg.func.powerdown_second_bit;
    assign sync_pd_armed = core_reg.func.powerdown_first_bit
        & core_reg.func.powerdown_second_bit;

    always_comb
    begin
        core_next = core_reg;
        core_next.le_meta = i_latch_enable_pin;
        core_next.le_sync = core_reg.le_meta;
        core_next.le_prev = core_reg.le_sync;
        core_next.ce_meta = i_chip_enable_pin;
        core_next.ce_sync = core_reg.ce_meta;
        core_next.reference_load = 1'b0;
        core_next.divide_load = 1'b0;
        core_next.reset_pulse = 1'b0;

        // writes land whatever the power state is
        if (le_rise)
        begin
            case (word_sel)
                SEL_REFERENCE:
                begin
                    core_next.reference_word = word_payload;
                    core_next.reference_load = 1'b1;
                end
                SEL_DIVIDE:
                begin
                    core_next.divide_word = word_payload;
                    core_next.divide_load = 1'b1;
                    if (core_reg.init_armed)
                    begin
                        core_next.reset_pulse = 1'b1;
                        core_next.init_armed = 1'b0;
                    end
                end
                SEL_FUNCTION:
                begin
                    core_next.func = word_func;
                end
                SEL_INIT:
                begin
                    core_next.func = word_func;
                    core_next.reset_pulse = 1'b1;
                    core_next.init_armed = 1'b1;
                end
                default:
                begin
                    core_next.func = core_reg.func;
                end
            endcase
        end

        // asynchronous programmed mode follows the bits directly
        core_next.async_pd_active = async_pd_armed;

        // synchronous mode waits for a pump event or the internal pulse;
        // the counter reset bit never arms it
        if (!sync_pd_armed)
        begin
            core_next.sync_pd_active = 1'b0;
        end
        else if (i_pump_event)
        begin
            core_next.sync_pd_active = 1'b1;
        end
        else if (core_reg.reset_pulse && core_reg.ce_sync)
        begin
            core_next.sync_pd_active = 1'b1;
        end

        // reset pulse with first power-down bit set, second bit clear and enable high
        if (core_reg.reset_pulse && core_reg.ce_sync && async_pd_armed)
        begin
            core_next.async_pd_active = 1'b1;
        end
    end

    // chip enable does not touch the latched settings, so they live on
    // through enable cycles with no rewrite
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            core_reg.le_meta <= 1'b0;
            core_reg.le_sync <= 1'b0;
            core_reg.le_prev <= 1'b0;
            core_reg.ce_meta <= 1'b0;
            core_reg.ce_sync <= 1'b0;
            core_reg.func <= scl_func_t'(FUNC_RESET);
            core_reg.reference_word <= COUNTER_WORD_RESET;
            core_reg.divide_word <= COUNTER_WORD_RESET;
            core_reg.reference_load <= 1'b0;
            core_reg.divide_load <= 1'b0;
            core_reg.init_armed <= 1'b0;
            core_reg.reset_pulse <= 1'b0;
            core_reg.sync_pd_active <= 1'b0;
            core_reg.async_pd_active <= 1'b0;
        end
        else if (i_clk_en)
        begin
            core_reg <= core_next;
        end
    end

    // ==========================================================
    // outputs to the synthesizer core
    logic programmed_pd;
    logic hold;

    assign programmed_pd = core_reg.async_pd_active | core_reg.sync_pd_active;

    // counters held by the counter reset bit, the pulse or any power-down;
    // the pulse touches only counters and pump, never the prescaler
    // reference or oscillator buffer, which have no control here
    assign hold = core_reg.func.counter_reset_bit
        | core_reg.reset_pulse
        | programmed_pd
        | ~core_reg.ce_sync;

    always_comb
    begin
        o_ctrl.func = core_reg.func;
        o_ctrl.reference_word = core_reg.reference_word;
        o_ctrl.divide_word = core_reg.divide_word;
        o_ctrl.reference_load = core_reg.reference_load;
        o_ctrl.divide_load = core_reg.divide_load;
        o_ctrl.reset_pulse = core_reg.reset_pulse;
        o_ctrl.counter_hold = hold;
        o_ctrl.pump_high_z = core_reg.func.pump_disable_bit | hold;
        o_ctrl.programmed_powerdown = programmed_pd;
    end

    // the raw pin is or-ed in so power-down follows it with no clock edge;
    // the synchronised copy keeps it asserted through the crossing
    assign o_powerdown = ~i_chip_enable_pin | ~core_reg.ce_sync | programmed_pd;

endmodule // scl_control_latch

`default_nettype wire

// *** core/scl_pkg.sv ***
// package: word layout, latch selects and carrier types of the synthesizer control latches
`default_nettype none

package scl_pkg;

    // ==========================================================
    // serial word layout
    localparam int WORD_W = 24;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam int PAYLOAD_LSB = 2;
    localparam int PAYLOAD_W = 22;

    // ==========================================================
    // latch selects carried in the two low bits
    localparam logic [1:0] SEL_REFERENCE = 2'h0;
    localparam logic [1:0] SEL_DIVIDE = 2'h1;
    localparam logic [1:0] SEL_FUNCTION = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    // ==========================================================
    // reset values
    localparam logic [PAYLOAD_W-1:0] FUNC_RESET = 22'h00_0000;
    localparam logic [PAYLOAD_W-1:0] COUNTER_WORD_RESET = 22'h00_0000;
    localparam logic [WORD_W-1:0] SHIFT_RESET = 24'h00_0000;

    // ==========================================================
    // function settings, word bits 23..2 from the msb down
    typedef struct packed {
        logic [1:0] prescaler_select;
        logic powerdown_second_bit;
        logic [2:0] pump_current_secondary;
        logic [2:0] pump_current_primary;
        logic [3:0] timer_select;
        logic fastlock_mode_bit;
        logic fastlock_enable_bit;
        logic pump_disable_bit;
        logic detector_polarity_bit;
        logic [2:0] monitor_select;
        logic powerdown_first_bit;
        logic counter_reset_bit;
    } scl_func_t;

    // ==========================================================
    // what the block hands to the synthesizer core
    typedef struct packed {
        scl_func_t func;
        logic [PAYLOAD_W-1:0] reference_word;
        logic [PAYLOAD_W-1:0] divide_word;
        logic reference_load;
        logic divide_load;
        logic reset_pulse;
        logic counter_hold;
        logic pump_high_z;
        logic programmed_powerdown;
    } scl_synth_ctrl_t;

endpackage : scl_pkg

`default_nettype wire

// *** testbench/scl_host_model.sv ***
// host model: serial word, latch enable and chip enable
`default_nettype none
module scl_host_model (
    input wire logic i_core_clk,
    output logic o_serial_clk,
    output logic o_serial_data,
    output logic o_latch_enable_pin,
    output logic o_chip_enable_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_serial_clk = 1'b0;
        o_serial_data = 1'b0;
        o_latch_enable_pin = 1'b0;
        o_chip_enable_pin = 1'b1;
    end
    // ====================
    // word transfer, msb first; clock runs only inside the frame
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            o_serial_data = w[i];
            #16 o_serial_clk = 1'b1;
            #16 o_serial_clk = 1'b0;
        end
        o_serial_data = ~w[0]; // idle line must not look like a held bit
        @(negedge i_core_clk) o_latch_enable_pin = 1'b1;
        repeat (4) @(negedge i_core_clk);
        o_latch_enable_pin = 1'b0;
        repeat (4) @(negedge i_core_clk);
    endtask
    task automatic set_ce(input logic v);
        @(negedge i_core_clk) o_chip_enable_pin = v;
        if (v)
            #1000; // bias settling after enable
    endtask
endmodule // scl_host_model
`default_nettype wire

// *** testbench/scl_monitor.sv ***
// checker: port-level timing of the control latch
`default_nettype none
module scl_monitor
    import scl_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_chip_enable_pin,
    input wire scl_pkg::scl_synth_ctrl_t o_ctrl,
    input wire logic o_powerdown
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ====================
    // assertions
    property p_ce_low; !i_chip_enable_pin |-> o_powerdown; endproperty
    a_ce_low: assert property (p_ce_low) else $error("no power-down");
    property p_hz; o_ctrl.func.pump_disable_bit |-> o_ctrl.pump_high_z; endproperty
    a_hz: assert property (p_hz) else $error("pump driven");
    property p_cr;
        o_ctrl.func.counter_reset_bit |-> o_ctrl.counter_hold && o_ctrl.pump_high_z;
    endproperty
    a_cr: assert property (p_cr) else $error("counters run");
    property p_pulse; o_ctrl.reset_pulse |-> o_ctrl.pump_high_z ##1 !o_ctrl.reset_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("bad reset pulse");
    property p_div; $changed(o_ctrl.divide_word) |-> o_ctrl.divide_load; endproperty
    a_div: assert property (p_div) else $error("divide word drift");
    property p_ref; $changed(o_ctrl.reference_word) |-> o_ctrl.reference_load; endproperty
    a_ref: assert property (p_ref) else $error("reference word drift");
    // the reset bit alone must never arm a power-down
    property p_no_pd;
        o_ctrl.func.counter_reset_bit && !o_ctrl.func.powerdown_first_bit
            && !$past(o_ctrl.func.powerdown_first_bit) |=> !o_ctrl.programmed_powerdown;
    endproperty
    a_no_pd: assert property (p_no_pd) else $error("reset bit powered down");
    property p_ce_up;
        (i_chip_enable_pin && i_clk_en)[*4] ##0 !o_ctrl.programmed_powerdown |-> !o_powerdown;
    endproperty
    a_ce_up: assert property (p_ce_up) else $error("stuck in power-down");
endmodule // scl_monitor
`default_nettype wire

// *** testbench/test_scl_control_latch.sv ***
// testbench: programming sequences of the synthesizer control latch
`default_nettype none
module test_scl_control_latch;
    timeunit 1ns;
    timeprecision 1ps;
    import scl_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_pump_event = 1'b0;
    wire logic sclk, sdat, le, ce;
    scl_synth_ctrl_t o_ctrl;
    logic o_powerdown;
    int err_count = 0;
    int n_compared = 0;
    int n_pulse = 0;
    int cyc = 0;
    always #25 i_core_clk = ~i_core_clk;
    scl_host_model i_host (.i_core_clk(i_core_clk), .o_serial_clk(sclk),
        .o_serial_data(sdat), .o_latch_enable_pin(le), .o_chip_enable_pin(ce));
    scl_control_latch i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
        .i_serial_clk(sclk), .i_serial_data(sdat), .i_latch_enable_pin(le),
        .i_chip_enable_pin(ce), .i_pump_event(i_pump_event), .o_ctrl(o_ctrl),
        .o_powerdown(o_powerdown));
    // ====================
    // compare and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // field positions checked against raw word bits, not the struct
    task automatic fchk(input logic [23:0] w);
        chk(o_ctrl.func.pump_current_primary, w[17:15]);
        chk(o_ctrl.func.pump_current_secondary, w[20:18]);
        chk(o_ctrl.func.detector_polarity_bit, w[7]);
        chk(o_ctrl.func, w[23:2]);
    endtask
    // pulse counter and hang guard; sampled on the falling edge, clear of the launch
    always @(negedge i_core_clk)
    begin
        cyc++;
        if (o_ctrl.reset_pulse === 1'b1)
            n_pulse++;
        if (cyc == 2000)
        begin
            err_count++;
            close_out();
        end
    end
    // ====================
    // sequences
    initial
    begin
        repeat (12) @(negedge i_core_clk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_core_clk);
        // prescaler 10 keeps a 4 GHz input in range
        i_host.send(24'h8e8083);
        fchk(24'h8e8083);
        chk(n_pulse, 1);
        chk(o_ctrl.pump_high_z, 1'b0);
        i_host.send(24'h8e8182);
        chk(o_ctrl.pump_high_z, 1'b1);
        i_host.send(24'h048d14);
        chk(o_ctrl.reference_word, 22'h012345);
        i_host.send(24'h02af35);
        chk(o_ctrl.divide_word, 22'h00abcd);
        chk(n_pulse, 2);
        i_host.send(24'h0048d1);
        chk(o_ctrl.divide_word, 22'h001234);
        chk(n_pulse, 2);
        i_host.send(24'h8e8086);
        chk(o_ctrl.counter_hold, 1'b1);
        chk(o_ctrl.programmed_powerdown, 1'b0);
        i_host.send(24'h048d14);
        i_host.send(24'h02af35);
        chk(n_pulse, 2);
        i_host.send(24'h8e8082);
        chk(o_ctrl.counter_hold, 1'b0);
        i_host.set_ce(1'b0);
        #1 chk(o_powerdown, 1'b1);
        i_host.send(24'h8e8182);
        i_host.send(24'h002af0);
        chk(o_ctrl.reference_word, 22'h000abc);
        i_host.send(24'h02af35);
        i_host.set_ce(1'b1);
        chk(o_powerdown, 1'b0);
        fchk(24'h8e8182);
        // synchronous power-down waits for a pump event
        i_host.send(24'hae818a);
        chk(o_ctrl.programmed_powerdown, 1'b0);
        @(negedge i_core_clk);
        i_pump_event = 1'b1;
        @(negedge i_core_clk);
        i_pump_event = 1'b0;
        chk(o_ctrl.programmed_powerdown, 1'b1);
        chk(o_powerdown, 1'b1);
        i_host.send(24'h8e8182);
        chk(o_ctrl.programmed_powerdown, 1'b0);
        // frozen core misses the latch enable, settings stay put
        @(negedge i_core_clk);
        i_clk_en = 1'b0;
        i_host.send(24'h8e8082);
        i_clk_en = 1'b1;
        repeat (4) @(negedge i_core_clk);
        fchk(24'h8e8182);
        chk(n_pulse, 2);
        i_host.send(24'h8e808b);
        chk(o_ctrl.programmed_powerdown, 1'b1);
        chk(o_powerdown, 1'b1);
        close_out();
    end
endmodule // test_scl_control_latch
bind scl_control_latch scl_monitor i_mon (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_chip_enable_pin(i_chip_enable_pin), .o_ctrl(o_ctrl),
    .o_powerdown(o_powerdown));
`default_nettype wire
